// file: logic/fcs_cmd_decode.v
`timescale 1ns/1ps
`default_nettype none
`include "fcs_defines.vh"

module fcs_cmd_decode
(
  // command code
  input  wire [7:0] code,
  // decoded kind
  output reg        legal,
  output reg        is_burst,
  output reg        is_blank,
  output reg        is_erase,
  output reg        is_mass
);

  always @*
  begin
    legal    = 1'b1;
    is_burst = 1'b0;
    is_blank = 1'b0;
    is_erase = 1'b0;
    is_mass  = 1'b0;
    case (code)
      `FCS_CMD_BLANK: is_blank = 1'b1;   // [R17]
      `FCS_CMD_BYTE:  legal = 1'b1;      // [R17]
      `FCS_CMD_BURST: is_burst = 1'b1;   // [R17]
      `FCS_CMD_PAGE:  is_erase = 1'b1;   // [R16]
      `FCS_CMD_MASS:
      begin
        is_erase = 1'b1;                 // [R16]
        is_mass  = 1'b1;
      end
      default:        legal = 1'b0;      // [R18]
    endcase
  end

endmodule
`default_nettype wire

// file: logic/fcs_defines.vh
// Function
// R1 - config bits 7:5 read/write, 4:0 zero
// R2 - key access off: window write starts command
// R3 - key access on: window writes capture key bytes
// R4 - reset loads protection from stored byte
// R5 - protect disable 0: only smaller select accepted
// R6 - protect disable 1: protection writes ignored
// R7 - select field bounds unprotected top region
// R8 - disable bit chooses protected block or none
// R9 - status bits 3,1,0 read zero
// R10 - write one to buffer-empty launches command
// R11 - only burst program commands are buffered
// R12 - complete set when idle, cleared on launch
// R13 - protected target: ignore, set violation flag
// R14 - sequence, divider, stop errors set access error
// R15 - blank flag set by erased blank check
// R16 - codes 40 page erase, 41 mass erase
// R17 - codes 05 blank, 20 byte, 25 burst
// R18 - other codes raise access error
// R19 - divider unwritten: loaded flag zero, no program
// R20 - blank or key success sets unsecured state
// R21 - writing zero to buffer-empty does nothing
`ifndef FCS_DEFINES_VH
`define FCS_DEFINES_VH

// ****************************************
// register offsets
// ****************************************
`define FCS_OFF_DIV      16'h1820
`define FCS_OFF_CFG      16'h1823
`define FCS_OFF_PROT     16'h1824
`define FCS_OFF_STAT     16'h1825
`define FCS_OFF_CMD      16'h1826
`define FCS_OFF_SEC      16'h1827
`define FCS_KEY_LO       16'hffb0
`define FCS_KEY_HI       16'hffb7

// ****************************************
// field positions and masks
// ****************************************
`define FCS_CFG_MASK     8'he0
`define FCS_CFG_KEYEN    5
`define FCS_ST_CBE       7
`define FCS_ST_CC        6
`define FCS_ST_PV        5
`define FCS_ST_AE        4
`define FCS_ST_BLANK     2
`define FCS_SEC_UNSEC    2'h2

// ****************************************
// commands
// ****************************************
`define FCS_CMD_BLANK    8'h05
`define FCS_CMD_BYTE     8'h20
`define FCS_CMD_BURST    8'h25
`define FCS_CMD_PAGE     8'h40
`define FCS_CMD_MASS     8'h41

// ****************************************
// timing counts (cycles of clk)
// ****************************************
`define FCS_OP_CYCLES    8'h20
`define FCS_BLANK_CYCLES 8'h40

`endif

// file: logic/fcs_top.v
// Implementation choices: the plain strobed port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "fcs_defines.vh"

module fcs_top
(
  // clock and reset
  input  wire        clk,
  input  wire        rst_b,
  // register port
  input  wire [15:0] addr,
  input  wire [7:0]  wdata,
  input  wire        wr,
  input  wire        rd,
  output reg  [7:0]  rdata_ff,
  // nonvolatile and array side
  input  wire [7:0]  stored_protection_byte,
  input  wire        array_erased,
  input  wire        key_match,
  input  wire        stop_req,
  output reg         array_start_ff,
  output reg  [7:0]  array_cmd_ff,
  output reg  [15:0] array_addr_ff,
  output reg  [7:0]  array_data_ff,
  output reg         key_wr_ff,
  output reg  [2:0]  key_idx_ff,
  output reg  [7:0]  key_byte_ff,
  output reg  [1:0]  security_state_ff
);

  // ****************************************
  // state
  // ****************************************
  localparam ST_IDLE = 2'h0;
  localparam ST_ADDR = 2'h1;
  localparam ST_CMD  = 2'h2;
  localparam ST_RUN  = 2'h3;

  reg  [1:0]  seq_ff;
  reg  [7:0]  cfg_ff;
  reg  [7:0]  prot_ff;
  reg         prot_loaded_ff;
  reg  [7:0]  div_ff;
  reg         divider_loaded_ff;
  reg         cmd_buffer_empty_ff;
  reg         cmd_complete_ff;
  reg         protection_violation_ff;
  reg         access_error_ff;
  reg         array_blank_ff;
  reg  [7:0]  flash_command_ff;
  reg  [15:0] lat_addr_ff;
  reg  [7:0]  lat_data_ff;
  reg         busy_ff;
  reg  [7:0]  cnt_ff;
  reg         run_blank_ff;
  reg         pend_ff;
  reg  [7:0]  pend_cmd_ff;
  reg  [15:0] pend_addr_ff;
  reg  [7:0]  pend_data_ff;

  wire        legal;
  wire        is_burst;
  wire        is_blank;
  wire        is_erase;
  wire        is_mass;

  fcs_cmd_decode u_dec
  (
    .code     (flash_command_ff),
    .legal    (legal),
    .is_burst (is_burst),
    .is_blank (is_blank),
    .is_erase (is_erase),
    .is_mass  (is_mass)
  );

  // ****************************************
  // decode of accesses
  // ****************************************
  wire key_win   = (addr >= `FCS_KEY_LO) && (addr <= `FCS_KEY_HI);
  wire key_en    = cfg_ff[`FCS_CFG_KEYEN];
  wire wr_cfg    = wr && (addr == `FCS_OFF_CFG);
  wire wr_prot   = wr && (addr == `FCS_OFF_PROT);
  wire wr_stat   = wr && (addr == `FCS_OFF_STAT);
  wire wr_cmd    = wr && (addr == `FCS_OFF_CMD);
  wire wr_div    = wr && (addr == `FCS_OFF_DIV);
  wire wr_key    = wr && key_win && key_en;                    // [R3]
  wire wr_array  = wr && !key_win && addr[15];
  wire wr_first  = wr && ((key_win && !key_en) || wr_array);   // [R2]
  wire launch    = wr_stat && wdata[`FCS_ST_CBE] && cmd_buffer_empty_ff; // [R10] [R21]

  // protected when protection active and either the address is at or below the select boundary or the command is a mass erase
  wire [15:0] lim = {prot_ff[7:1], 9'h1ff};
  wire prot_hit  = !prot_ff[0] && (is_mass || (lat_addr_ff <= lim)); // [R7] [R8]
  wire writes_array = is_erase || !is_blank;
  wire can_queue = busy_ff && is_burst && !pend_ff && (array_cmd_ff == `FCS_CMD_BURST); // [R11]
  wire bad_seq   = (seq_ff != ST_CMD) || !legal;                // [R14] [R18]
  wire bad_div   = writes_array && !divider_loaded_ff;          // [R19]
  wire bad_busy  = busy_ff && !can_queue;                       // [R11]
  wire accept    = launch && !bad_seq && !bad_div && !bad_busy && !(writes_array && prot_hit);
  wire run_done  = busy_ff && (cnt_ff == 8'h00);

  // ****************************************
  // sequencer and registers
  // ****************************************
  always @(posedge clk)
  begin
    if (!rst_b)
    begin
      seq_ff                  <= ST_IDLE;
      cfg_ff                  <= 8'h00;
      prot_ff                 <= 8'hff;
      prot_loaded_ff          <= 1'b0;
      div_ff                  <= 8'h00;
      divider_loaded_ff       <= 1'b0;
      cmd_buffer_empty_ff     <= 1'b1;
      cmd_complete_ff         <= 1'b1;
      protection_violation_ff <= 1'b0;
      access_error_ff         <= 1'b0;
      array_blank_ff          <= 1'b0;
      flash_command_ff        <= 8'h00;
      lat_addr_ff             <= 16'h0000;
      lat_data_ff             <= 8'h00;
      busy_ff                 <= 1'b0;
      cnt_ff                  <= 8'h00;
      run_blank_ff            <= 1'b0;
      pend_ff                 <= 1'b0;
      pend_cmd_ff             <= 8'h00;
      pend_addr_ff            <= 16'h0000;
      pend_data_ff            <= 8'h00;
      array_start_ff          <= 1'b0;
      array_cmd_ff            <= 8'h00;
      array_addr_ff           <= 16'h0000;
      array_data_ff           <= 8'h00;
      key_wr_ff               <= 1'b0;
      key_idx_ff              <= 3'h0;
      key_byte_ff             <= 8'h00;
      security_state_ff       <= 2'h3;
    end
    else
    begin
      array_start_ff <= 1'b0;
      key_wr_ff      <= 1'b0;

      // protection byte copied once after reset release
      if (!prot_loaded_ff)
      begin
        prot_ff        <= stored_protection_byte;               // [R4]
        prot_loaded_ff <= 1'b1;
      end
      else if (wr_prot && !prot_ff[0] && (wdata[7:1] < prot_ff[7:1]))
      begin
        prot_ff[7:1] <= wdata[7:1];                             // [R5] [R6]
      end

      if (wr_cfg)
      begin
        cfg_ff <= wdata & `FCS_CFG_MASK;                        // [R1]
      end

      if (wr_div)
      begin
        div_ff            <= wdata;
        divider_loaded_ff <= 1'b1;                              // [R19]
      end

      if (wr_key)
      begin
        key_wr_ff   <= 1'b1;                                    // [R3]
        key_idx_ff  <= addr[2:0];
        key_byte_ff <= wdata;
      end

      if (key_match)
      begin
        security_state_ff <= `FCS_SEC_UNSEC;                    // [R20]
      end

      // command sequence: array write, command write, launch
      case (seq_ff)
        ST_IDLE:
        begin
          if (wr_first)
          begin
            lat_addr_ff <= addr;
            lat_data_ff <= wdata;
            seq_ff      <= ST_ADDR;
          end
          else if (wr_cmd || launch)
          begin
            access_error_ff <= 1'b1;                            // [R14]
          end
        end
        ST_ADDR:
        begin
          if (wr_cmd)
          begin
            flash_command_ff <= wdata;
            seq_ff           <= ST_CMD;
          end
          else if (wr_first || launch)
          begin
            access_error_ff <= 1'b1;                            // [R14]
            seq_ff          <= ST_IDLE;
          end
        end
        ST_CMD:
        begin
          if (launch)
          begin
            seq_ff <= ST_IDLE;
          end
          else if (wr_first || wr_cmd)
          begin
            access_error_ff <= 1'b1;                            // [R14]
            seq_ff          <= ST_IDLE;
          end
        end
        default:
        begin
          seq_ff <= ST_IDLE;
        end
      endcase

      // launch handling
      if (launch)
      begin
        if (!accept && !(writes_array && prot_hit && !bad_seq && !bad_div && !bad_busy))
        begin
          access_error_ff <= 1'b1;                              // [R14] [R18]
        end
        else if (!accept)
        begin
          protection_violation_ff <= 1'b1;                      // [R13]
        end
      end
      else if (wr_stat)
      begin
        if (wdata[`FCS_ST_PV])
        begin
          protection_violation_ff <= 1'b0;                      // [R13]
        end
        if (wdata[`FCS_ST_AE])
        begin
          access_error_ff <= 1'b0;                              // [R14]
        end
      end

      if (accept && busy_ff)
      begin
        pend_ff             <= 1'b1;                            // [R11]
        pend_cmd_ff         <= flash_command_ff;
        pend_addr_ff        <= lat_addr_ff;
        pend_data_ff        <= lat_data_ff;
        cmd_buffer_empty_ff <= 1'b0;                            // [R10]
        array_blank_ff      <= 1'b0;                            // [R15]
      end
      else if (accept)
      begin
        busy_ff             <= 1'b1;
        cnt_ff              <= is_blank ? `FCS_BLANK_CYCLES : `FCS_OP_CYCLES;
        run_blank_ff        <= is_blank;
        array_start_ff      <= 1'b1;
        array_cmd_ff        <= flash_command_ff;
        array_addr_ff       <= lat_addr_ff;
        array_data_ff       <= lat_data_ff;
        cmd_complete_ff     <= 1'b0;                            // [R12]
        array_blank_ff      <= 1'b0;                            // [R15]
        // command moved straight to the array, so the buffer is free again
        cmd_buffer_empty_ff <= 1'b1;                            // [R10]
      end
      else if (stop_req && busy_ff)
      begin
        access_error_ff     <= 1'b1;                            // [R14]
        busy_ff             <= 1'b0;
        pend_ff             <= 1'b0;
        cmd_buffer_empty_ff <= 1'b1;
        cmd_complete_ff     <= 1'b1;
      end
      else if (run_done)
      begin
        if (run_blank_ff && array_erased)
        begin
          array_blank_ff    <= 1'b1;                            // [R15]
          security_state_ff <= `FCS_SEC_UNSEC;                  // [R20]
        end
        if (pend_ff)
        begin
          // buffered burst byte moves to the array
          pend_ff             <= 1'b0;
          cnt_ff              <= `FCS_OP_CYCLES;
          run_blank_ff        <= 1'b0;
          array_start_ff      <= 1'b1;
          array_cmd_ff        <= pend_cmd_ff;
          array_addr_ff       <= pend_addr_ff;
          array_data_ff       <= pend_data_ff;
          cmd_buffer_empty_ff <= 1'b1;                          // [R10]
        end
        else
        begin
          busy_ff             <= 1'b0;
          cmd_buffer_empty_ff <= 1'b1;                          // [R10]
          cmd_complete_ff     <= 1'b1;                          // [R12]
        end
      end
      else if (busy_ff)
      begin
        cnt_ff <= cnt_ff - 8'h01;
      end
    end
  end

  // ****************************************
  // read data
  // ****************************************
  always @(posedge clk)
  begin
    if (!rst_b)
    begin
      rdata_ff <= 8'h00;
    end
    else if (rd)
    begin
      case (addr)
        `FCS_OFF_DIV:  rdata_ff <= {divider_loaded_ff, div_ff[6:0]}; // [R19]
        `FCS_OFF_CFG:  rdata_ff <= cfg_ff;                          // [R1]
        `FCS_OFF_PROT: rdata_ff <= prot_ff;                         // [R4]
        `FCS_OFF_STAT: rdata_ff <= {cmd_buffer_empty_ff, cmd_complete_ff,
                                    protection_violation_ff, access_error_ff,
                                    1'b0, array_blank_ff, 2'h0};   // [R9]
        `FCS_OFF_CMD:  rdata_ff <= flash_command_ff;
        `FCS_OFF_SEC:  rdata_ff <= {6'h00, security_state_ff};
        default:       rdata_ff <= 8'h00;
      endcase
    end
    else
    begin
      rdata_ff <= 8'h00;
    end
  end

endmodule
`default_nettype wire

// file: tb/fcs_asserts.sv
`timescale 1ns/1ps
`default_nettype none
`include "fcs_defines.vh"

module fcs_asserts
(
  // watched ports
  input wire logic        clk,
  input wire logic        rst_b,
  input wire logic [15:0] addr,
  input wire logic [7:0]  wdata,
  input wire logic        wr,
  input wire logic        rd,
  input wire logic [7:0]  rdata_ff,
  input wire logic [7:0]  stored_protection_byte,
  input wire logic        key_match,
  input wire logic        array_start_ff,
  input wire logic [7:0]  array_cmd_ff,
  input wire logic [15:0] array_addr_ff,
  input wire logic        key_wr_ff,
  input wire logic [2:0]  key_idx_ff,
  input wire logic [7:0]  key_byte_ff,
  input wire logic [1:0]  security_state_ff
);
  // ****
  // shadow of software-visible state
  // ****
  logic       key_en_ff;
  logic       div_ff;
  logic       first_ff;
  logic [7:0] cmd_ff;
  logic [7:0] prot_ff;
  wire logic  key_win = addr >= `FCS_KEY_LO && addr <= `FCS_KEY_HI;

  always @(posedge clk)
  begin
    if (!rst_b)
    begin
      key_en_ff <= 1'b0;
      div_ff    <= 1'b0;
      first_ff  <= 1'b1;
      cmd_ff    <= 8'h00;
      prot_ff   <= 8'hff;
    end
    else
    begin
      first_ff <= 1'b0;
      if (wr && addr == `FCS_OFF_CFG)
        key_en_ff <= wdata[`FCS_CFG_KEYEN];
      if (wr && addr == `FCS_OFF_DIV)
        div_ff <= 1'b1;
      if (wr && addr == `FCS_OFF_CMD)
        cmd_ff <= wdata;
      if (first_ff)
        prot_ff <= stored_protection_byte;
      else if (wr && addr == `FCS_OFF_PROT && !prot_ff[0] && wdata[7:1] < prot_ff[7:1])
        prot_ff <= {wdata[7:1], prot_ff[0]};
    end
  end

  // ****
  // properties
  // ****
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  sequence s_read(logic [15:0] a);
    $past(rd) && $past(addr) == a;
  endsequence
  sequence s_key_wr;
    wr && key_win && key_en_ff;
  endsequence

  a_cfg_low: assert property (s_read(`FCS_OFF_CFG) |-> rdata_ff[4:0] == 5'h00)
    else $error("config low bits not zero");
  a_stat_zero: assert property (s_read(`FCS_OFF_STAT) |-> (rdata_ff & 8'h0b) == 8'h00)
    else $error("status reserved bits not zero");
  a_prot_read: assert property (s_read(`FCS_OFF_PROT) |-> rdata_ff == $past(prot_ff))
    else $error("protection readback wrong");
  a_key_cap: assert property (s_key_wr |=> key_wr_ff && key_idx_ff == $past(addr[2:0])
    && key_byte_ff == $past(wdata))
    else $error("key byte not captured");
  a_key_off: assert property (wr && key_win && !key_en_ff |=> !key_wr_ff)
    else $error("key captured while disabled");
  a_start_code: assert property (array_start_ff |-> array_cmd_ff inside {`FCS_CMD_BLANK,
    `FCS_CMD_BYTE, `FCS_CMD_BURST, `FCS_CMD_PAGE, `FCS_CMD_MASS})
    else $error("illegal code started");
  a_start_cmd: assert property (array_start_ff |-> array_cmd_ff == cmd_ff)
    else $error("started code differs");
  a_div_gate: assert property (array_start_ff && array_cmd_ff != `FCS_CMD_BLANK |-> div_ff)
    else $error("start before divider written");
  a_prot_block: assert property (array_start_ff && !prot_ff[0] && array_cmd_ff != `FCS_CMD_BLANK
    |-> array_cmd_ff != `FCS_CMD_MASS && array_addr_ff > {prot_ff[7:1], 9'h1ff})
    else $error("protected target started");
  a_key_unsec: assert property (key_match |=> security_state_ff == `FCS_SEC_UNSEC)
    else $error("key match left device secure");
endmodule

bind fcs_top fcs_asserts i_fcs_asserts
(
  .clk, .rst_b, .addr, .wdata, .wr, .rd, .rdata_ff, .stored_protection_byte, .key_match,
  .array_start_ff, .array_cmd_ff, .array_addr_ff, .key_wr_ff, .key_idx_ff, .key_byte_ff,
  .security_state_ff
);
`default_nettype wire

// file: tb/fcs_flash_model.sv
`timescale 1ns/1ps
`default_nettype none
`include "fcs_defines.vh"

module fcs_flash_model
#(
  parameter logic [63:0] KEY = 64'h0123456789abcdef
)
(
  // bench controls
  input  wire logic       clk,
  input  wire logic [7:0] prot_nv,
  input  wire logic       stop_in,
  // engine side
  input  wire logic       array_start_ff,
  input  wire logic [7:0] array_cmd_ff,
  input  wire logic       key_wr_ff,
  input  wire logic [2:0] key_idx_ff,
  input  wire logic [7:0] key_byte_ff,
  output wire logic [7:0] stored_protection_byte,
  output var  logic       array_erased,
  output var  logic       key_match,
  output wire logic       stop_req
);
  logic [7:0] ok_ff = 8'h00;
  wire logic  hit   = key_byte_ff == KEY[63 - 8 * key_idx_ff -: 8];

  assign stored_protection_byte = prot_nv;
  assign stop_req = stop_in;
  initial array_erased = 1'b0;
  initial key_match = 1'b0;

  always @(posedge clk)
  begin
    key_match <= 1'b0;
    if (array_start_ff && array_cmd_ff == `FCS_CMD_MASS)
      array_erased <= 1'b1;
    else if (array_start_ff && array_cmd_ff != `FCS_CMD_BLANK)
      array_erased <= 1'b0;
    if (key_wr_ff)
    begin
      ok_ff[key_idx_ff] <= hit;
      key_match <= key_idx_ff == 3'h7 && hit && &ok_ff[6:0];
    end
  end
endmodule
`default_nettype wire

// file: tb/tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "fcs_defines.vh"

module tb;
  localparam logic [63:0] KEY = 64'h0123456789abcdef;
  logic clk = 0, rst_b = 0, wr = 0, rd = 0, stop_in = 0;
  logic [15:0] addr = 0;
  logic [7:0] wdata = 0, prot_nv = 8'hff, v;
  wire logic [7:0] rdata_ff, spb, a_cmd, k_byte, a_data;
  wire logic [15:0] a_addr;
  wire logic [2:0] k_idx;
  wire logic [1:0] sec;
  wire logic a_erased, k_match, stop_req, a_start, k_wr;
  int error_cnt = 0, n_tests = 0, starts = 0, s0, cyc = 0;
  logic [7:0] codes [5] = '{`FCS_CMD_MASS, `FCS_CMD_BLANK, `FCS_CMD_BYTE, `FCS_CMD_BURST, `FCS_CMD_PAGE};

  fcs_top i_fcs_top (.clk, .rst_b, .addr, .wdata, .wr, .rd, .rdata_ff, .stored_protection_byte(spb),
    .array_erased(a_erased), .key_match(k_match), .stop_req, .array_start_ff(a_start), .array_cmd_ff(a_cmd),
    .array_addr_ff(a_addr), .array_data_ff(a_data), .key_wr_ff(k_wr), .key_idx_ff(k_idx), .key_byte_ff(k_byte),
    .security_state_ff(sec));
  fcs_flash_model #(.KEY(KEY)) i_fcs_flash_model (.clk, .prot_nv, .stop_in, .array_start_ff(a_start),
    .array_cmd_ff(a_cmd), .key_wr_ff(k_wr), .key_idx_ff(k_idx), .key_byte_ff(k_byte),
    .stored_protection_byte(spb), .array_erased(a_erased), .key_match(k_match), .stop_req);

  // ****
  // clock, start monitor, timeout
  // ****
  initial forever #50 clk = ~clk;
  always @(negedge clk) if (a_start) starts++;
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      error_cnt++;
      tally_and_finish();
    end
  end

  // ****
  // bus tasks and checks
  // ****
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_tests++;
    if (g !== e)
    begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk) addr <= a; wdata <= d; wr <= 1'b1;
    @(posedge clk) wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [15:0] a);
    @(posedge clk) addr <= a; rd <= 1'b1;
    @(posedge clk) rd <= 1'b0;
    #1 v = rdata_ff;
  endtask
  task automatic rd_chk(input logic [15:0] a, input logic [7:0] e, input string nm);
    rd_reg(a);
    chk(nm, e, v);
  endtask
  task automatic launch(input logic [15:0] a, input logic [7:0] c);
    s0 = starts;
    wr_reg(a, 8'h5a);
    wr_reg(`FCS_OFF_CMD, c);
    wr_reg(`FCS_OFF_STAT, 8'h80);
  endtask
  task automatic wait_done();
    for (int i = 0; i < 100; i++)
    begin
      rd_reg(`FCS_OFF_STAT);
      if (v[`FCS_ST_CC] === 1'b1) break;
    end
  endtask
  task automatic do_reset(input logic [7:0] nv);
    @(posedge clk) rst_b <= 1'b0; prot_nv <= nv;
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // ****
  // tests
  // ****
  initial
  begin
    do_reset(8'hff);
    rd_chk(`FCS_OFF_STAT, 8'hc0, "status");
    rd_chk(`FCS_OFF_PROT, 8'hff, "prot");
    chk("security", 8'h03, {6'h0, sec});
    wr_reg(`FCS_OFF_CFG, 8'hff);
    rd_chk(`FCS_OFF_CFG, 8'he0, "config");
    wr_reg(`FCS_OFF_PROT, 8'h00);
    rd_chk(`FCS_OFF_PROT, 8'hff, "prot");
    wr_reg(`FCS_OFF_STAT, 8'h0f);
    rd_chk(`FCS_OFF_STAT, 8'hc0, "status");
    launch(16'h8000, `FCS_CMD_BYTE);
    rd_chk(`FCS_OFF_STAT, 8'hd0, "status");
    wr_reg(`FCS_OFF_STAT, 8'h10);
    wr_reg(`FCS_OFF_STAT, 8'h80);
    rd_chk(`FCS_OFF_STAT, 8'hd0, "status");
    wr_reg(`FCS_OFF_STAT, 8'h10);
    rd_chk(`FCS_OFF_STAT, 8'hc0, "status");
    chk("starts", 8'h00, 8'(starts));
    wr_reg(`FCS_OFF_DIV, 8'h31);
    rd_reg(`FCS_OFF_DIV);
    chk("div_loaded", 8'h01, {7'h0, v[7]});
    $display("test basics done");
    for (int i = 0; i < 8; i++) wr_reg(`FCS_KEY_LO + 16'(i), KEY[63 - 8 * i -: 8]);
    repeat (4) @(posedge clk);
    chk("security", 8'h02, {6'h0, sec});
    chk("starts", 8'h00, 8'(starts));
    wr_reg(`FCS_OFF_CFG, 8'h00);
    launch(16'hffb3, `FCS_CMD_PAGE);
    wait_done();
    chk("window start", 8'h01, 8'(starts - s0));
    $display("test key window done");
    foreach (codes[k])
    begin
      launch(16'hc000, codes[k]);
      rd_chk(`FCS_OFF_STAT, 8'h80, "busy status");
      chk("code", codes[k], a_cmd);
      chk("data", 8'h5a, a_data);
      chk("addr", 8'hc0, a_addr[15:8]);
      wait_done();
      chk("done status", codes[k] == `FCS_CMD_BLANK ? 8'hc4 : 8'hc0, v);
    end
    launch(16'hc000, 8'h77);
    rd_chk(`FCS_OFF_STAT, 8'hd0, "status");
    wr_reg(`FCS_OFF_STAT, 8'h10);
    launch(16'hc000, `FCS_CMD_BURST);
    launch(16'hc100, `FCS_CMD_BURST);
    rd_chk(`FCS_OFF_STAT, 8'h00, "buffered");
    wait_done();
    chk("bursts", 8'hc0, v);
    launch(16'hc000, `FCS_CMD_BURST);
    launch(16'hc100, `FCS_CMD_BYTE);
    rd_chk(`FCS_OFF_STAT, 8'h90, "queued byte");
    wait_done();
    wr_reg(`FCS_OFF_STAT, 8'h10);
    launch(16'hc000, `FCS_CMD_PAGE);
    @(posedge clk) stop_in <= 1'b1;
    @(posedge clk) stop_in <= 1'b0;
    wait_done();
    chk("stop status", 8'hd0, v);
    $display("test commands done");
    do_reset(8'h80);
    rd_chk(`FCS_OFF_PROT, 8'h80, "prot");
    wr_reg(`FCS_OFF_DIV, 8'h31);
    launch(16'h8000, `FCS_CMD_BYTE);
    rd_chk(`FCS_OFF_STAT, 8'he0, "violation");
    launch(16'hc000, `FCS_CMD_MASS);
    rd_chk(`FCS_OFF_STAT, 8'he0, "violation");
    wr_reg(`FCS_OFF_STAT, 8'h20);
    rd_chk(`FCS_OFF_STAT, 8'hc0, "cleared");
    launch(16'hc000, `FCS_CMD_BYTE);
    wait_done();
    chk("open start", 8'h01, 8'(starts - s0));
    wr_reg(`FCS_OFF_PROT, 8'h40);
    rd_chk(`FCS_OFF_PROT, 8'h40, "prot");
    wr_reg(`FCS_OFF_PROT, 8'h60);
    rd_chk(`FCS_OFF_PROT, 8'h40, "prot");
    $display("test protection done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
